/* File: utr_params.svh */
// register offsets, reset values and field positions for the test bank
// assumes inclusion by bare name from the package and the bank files
`ifndef UTR_PARAMS_SVH
`define UTR_PARAMS_SVH
`define UTR_OFS_PRODUCT 6'h00
`define UTR_OFS_REVISION 6'h01
`define UTR_OFS_MOTION 6'h02
`define UTR_OFS_XDISP 6'h03
`define UTR_OFS_YDISP 6'h04
`define UTR_OFS_SURFACE_QUALITY 6'h05
`define UTR_OFS_EXP_HI 6'h06
`define UTR_OFS_EXP_LO 6'h07
`define UTR_OFS_PIX_MAX 6'h08
`define UTR_OFS_PIX_AVG 6'h09
`define UTR_OFS_PIX_MIN 6'h0A
`define UTR_OFS_PIX_DUMP 6'h0B
`define UTR_OFS_WHEEL 6'h0C
`define UTR_OFS_SETUP 6'h0D
`define UTR_OFS_INV_REV 6'h3F
`define UTR_BIT_VALID 7
`define UTR_BTN_MSB 4
`define UTR_SETUP_RST 8'h00
`define UTR_ZERO_BYTE 8'h00
// product code is arbitrary, not a real part value
`define UTR_PRODUCT_CODE 8'hA7
// revision code is arbitrary
`define UTR_REVISION_CODE 8'h10
`define UTR_NUM_REGS 64
`endif

/* File: utr_pkg.sv */
// types shared by the test register bank and its store
// assumes utr_params.svh is on the include path
`include "utr_params.svh"
package utr_pkg;
  // one vendor test request from the usb engine
  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } utr_req_t;
  // answer back to the usb engine
  typedef struct packed {
    logic ack;
    logic refused;
    logic [7:0] rdata;
  } utr_rsp_t;
  // image statistics from the navigation datapath
  typedef struct packed {
    logic [7:0] surface_quality;
    logic [15:0] exposure;
    logic [7:0] pix_max;
    logic [7:0] pix_avg;
    logic [7:0] pix_min;
    logic [7:0] pix_dump;
    logic [7:0] wheel;
    logic [7:0] ydisp;
  } utr_stats_t;
  typedef enum logic [1:0] {
    UTR_IDLE = 2'b00,
    UTR_ANSWER = 2'b01
  } utr_state_t;
endpackage

/* File: utr_enable_store.sv */
// per-register enable flags for the test bank
// assumes clear comes from usb bus reset, held one cycle; power loss arrives on rst_n
`include "utr_params.svh"
module utr_enable_store
  import utr_pkg::*;
#(
  parameter int NREGS = `UTR_NUM_REGS
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clear_all,
  input wire logic set_en,
  input wire logic [5:0] set_idx,
  input wire logic [5:0] rd_idx,
  output logic rd_en
);
  logic [NREGS-1:0] en_reg;

  initial
  begin
    if (NREGS != 64)
      $error("utr_enable_store serves exactly 64 entries");
  end

  ////////////////////////////////////////////////////////////////////////
  // one flag per register; bus reset clears all
  genvar g;
  generate
    for (g = 0; g < NREGS; g++)
    begin : g_en
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          en_reg[g] <= 1'b0;
        else if (clear_all)
          en_reg[g] <= 1'b0;
        else if (set_en && set_idx == 6'(g))
          en_reg[g] <= 1'b1;
      end
    end
  endgenerate

  // registered read port, answers one cycle later
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_en <= 1'b0;
    else
      rd_en <= en_reg[rd_idx];
  end
endmodule

/* File: utr_bank.sv */
// test and diagnostic register bank reached by usb vendor test requests
// assumes the usb engine presents one request per pulse and a bus reset
// pulse; supply loss appears as rst_n.
`include "utr_params.svh"
module utr_bank
  import utr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic usb_bus_reset,
  input utr_req_t req,
  output utr_rsp_t rsp,
  input wire logic report_valid_flag,
  input wire logic [4:0] btn_debounced,
  input wire logic [7:0] report_x,
  input utr_stats_t stats,
  input wire logic enable_pulse,
  input wire logic [5:0] enable_idx,
  input wire logic [63:0] gated_map,
  output logic [7:0] setup_bits
);
  utr_state_t state_reg;
  logic [5:0] addr_reg;
  logic wr_reg;
  logic [7:0] wdata_reg;
  logic x_seen_reg;
  logic idx_en;
  logic [7:0] rdata_next;
  logic mapped;

  ////////////////////////////////////////////////////////////////////////
  // enable flags live in their own store
  // clear on bus reset
  utr_enable_store #(.NREGS(`UTR_NUM_REGS)) utr_enable_store_i (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear_all(usb_bus_reset),
    .set_en(enable_pulse),
    .set_idx(enable_idx),
    .rd_idx(req.addr),
    .rd_en(idx_en)
  );

  ////////////////////////////////////////////////////////////////////////
  // capture a request, answer it in the next cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= UTR_IDLE;
    else if (usb_bus_reset)
      state_reg <= UTR_IDLE;
    else
      case (state_reg)
        UTR_IDLE: if (req.rd || req.wr) state_reg <= UTR_ANSWER;
        UTR_ANSWER: state_reg <= UTR_IDLE;
        default: state_reg <= UTR_IDLE;
      endcase
  end

  // request fields held for the answer cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_reg <= 6'h00;
      wr_reg <= 1'b0;
      wdata_reg <= 8'h00;
    end
    else if (state_reg == UTR_IDLE && (req.rd || req.wr))
    begin
      addr_reg <= req.addr;
      wr_reg <= req.wr;
      wdata_reg <= req.wdata;
    end
  end

  // a gated register that is not yet enabled is refused
  // refuse until enabled
  logic allowed;
  assign allowed = !gated_map[addr_reg] || idx_en;

  // decode of printed offsets; others answer refused
  always_comb
  begin
    mapped = 1'b1;
    rdata_next = `UTR_ZERO_BYTE;
    case (addr_reg)
      `UTR_OFS_PRODUCT: rdata_next = `UTR_PRODUCT_CODE;
      `UTR_OFS_REVISION: rdata_next = `UTR_REVISION_CODE;
      `UTR_OFS_MOTION:
        rdata_next = {report_valid_flag, 2'b00, btn_debounced};
      `UTR_OFS_XDISP: rdata_next = report_x;
      `UTR_OFS_YDISP:
        rdata_next = x_seen_reg ? stats.ydisp : `UTR_ZERO_BYTE;
      `UTR_OFS_SURFACE_QUALITY: rdata_next = stats.surface_quality;
      `UTR_OFS_EXP_HI: rdata_next = stats.exposure[15:8];
      `UTR_OFS_EXP_LO: rdata_next = stats.exposure[7:0];
      `UTR_OFS_PIX_MAX: rdata_next = stats.pix_max;
      `UTR_OFS_PIX_AVG: rdata_next = stats.pix_avg;
      `UTR_OFS_PIX_MIN: rdata_next = stats.pix_min;
      `UTR_OFS_PIX_DUMP: rdata_next = stats.pix_dump;
      `UTR_OFS_WHEEL: rdata_next = stats.wheel;
      `UTR_OFS_SETUP: rdata_next = setup_bits;
      `UTR_OFS_INV_REV: rdata_next = ~`UTR_REVISION_CODE;
      default: mapped = 1'b0;
    endcase
  end

  logic do_access;
  assign do_access = state_reg == UTR_ANSWER && mapped && allowed;

  // x read arms the y read; y read or bus reset disarms it
  // read order
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      x_seen_reg <= 1'b0;
    else if (usb_bus_reset)
      x_seen_reg <= 1'b0;
    else if (do_access && !wr_reg && addr_reg == `UTR_OFS_XDISP)
      x_seen_reg <= 1'b1;
    else if (do_access && !wr_reg && addr_reg == `UTR_OFS_YDISP)
      x_seen_reg <= 1'b0;
  end

  // the only writable register steers the sensor setup
  // host programs setup
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      setup_bits <= `UTR_SETUP_RST;
    else if (do_access && wr_reg && addr_reg == `UTR_OFS_SETUP)
      setup_bits <= wdata_reg;
  end

  // answer, one cycle pulse two edges after the request
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rsp <= '0;
    else
    begin
      rsp.ack <= state_reg == UTR_ANSWER;
      rsp.refused <= state_reg == UTR_ANSWER && !(mapped && allowed);
      rsp.rdata <= (do_access && !wr_reg) ? rdata_next : `UTR_ZERO_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  // flag on bit 7
  motion_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == UTR_ANSWER && addr_reg == `UTR_OFS_MOTION && !wr_reg
     && allowed) |=> rsp.rdata[`UTR_BIT_VALID] == $past(report_valid_flag))
    else $error("motion flag not mirrored");
  motion_buttons_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == UTR_ANSWER && addr_reg == `UTR_OFS_MOTION && !wr_reg
     && allowed) |=> rsp.rdata[6:0] == {2'b00, $past(btn_debounced)})
    else $error("button bits wrong");
  gated_refuse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == UTR_ANSWER && !allowed) |=> rsp.refused && rsp.rdata == 8'h00)
    else $error("gated register served");
  y_order_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == UTR_ANSWER && addr_reg == `UTR_OFS_YDISP && !x_seen_reg)
    |=> rsp.rdata == 8'h00)
    else $error("y read before x not zero");
  x_value_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (do_access && !wr_reg && addr_reg == `UTR_OFS_XDISP)
    |=> rsp.rdata == $past(report_x))
    else $error("x value wrong");
  setup_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (do_access && wr_reg && addr_reg == `UTR_OFS_SETUP)
    |=> setup_bits == $past(wdata_reg))
    else $error("setup write lost");
  bus_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    usb_bus_reset |=> !x_seen_reg && state_reg == UTR_IDLE)
    else $error("bus reset ignored");
  answer_time_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == UTR_IDLE && (req.rd || req.wr) && !usb_bus_reset)
    |=> ##1 rsp.ack)
    else $error("answer late");
  cov_motion_c: cover property (@(posedge ref_clk)
    do_access && addr_reg == `UTR_OFS_MOTION);
  cov_xy_c: cover property (@(posedge ref_clk)
    do_access && addr_reg == `UTR_OFS_YDISP && x_seen_reg);
  cov_refuse_c: cover property (@(posedge ref_clk) rsp.refused);
endmodule

/* File: utr_host_model.sv */
// host model: issues vendor test requests to the bank
// assumes an answer comes within eight cycles of a request
module utr_host_model
  import utr_pkg::*;
(
  input wire logic ref_clk,
  output utr_req_t req,
  input utr_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus until the first request
  initial req = '0;
  task automatic xfer(input logic w, input logic [13:0] aw,
    output logic [8:0] r);
    int n;
    r = 9'h1FF;
    @(posedge ref_clk);
    req <= {~w, w, aw};
    @(posedge ref_clk);
    // released lines carry inverted values so stale data never matches
    req <= {2'b00, ~aw};
    for (n = 0; n < 8; n++)
    begin
      @(negedge ref_clk);
      if (rsp.ack === 1'b1 || rsp.refused === 1'b1)
      begin
        r = {rsp.refused, rsp.rdata};
        break;
      end
    end
  endtask
endmodule

/* File: usb_test_register_bank_tb.sv */
// bench for the usb test register bank
// assumes utr_params.svh and the host model are compiled alongside
`include "utr_params.svh"
module usb_test_register_bank_tb;
  import utr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst_n = 0, usb_bus_reset = 0, valid = 0, en_p = 0;
  logic [4:0] btn = '0;
  logic [7:0] rx = '0, setup_bits;
  logic [5:0] en_idx = '0;
  logic [63:0] gmap = '0;
  logic [8:0] r;
  utr_req_t req;
  utr_rsp_t rsp;
  utr_stats_t stats = '0;
  int miscompares = 0, checks = 0;
  utr_bank utr_bank_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .usb_bus_reset(usb_bus_reset), .req(req), .rsp(rsp),
    .report_valid_flag(valid), .btn_debounced(btn), .report_x(rx),
    .stats(stats), .enable_pulse(en_p), .enable_idx(en_idx),
    .gated_map(gmap), .setup_bits(setup_bits));
  utr_host_model utr_host_model_i (.ref_clk(ref_clk), .req(req),
    .rsp(rsp));
  // free running clock, 8 ns period
  always #4 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////
  // compare {refused, data}; four-state so x never matches
  task automatic chk(input logic [8:0] g, e);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [8:0] e);
    utr_host_model_i.xfer(1'b0, {a, 8'h00}, r);
    chk(r, e);
  endtask
  // a write answers with ack and zero data, or refused
  task automatic wr(input logic [5:0] a, input logic [7:0] d,
    input logic [8:0] e);
    utr_host_model_i.xfer(1'b1, {a, d}, r);
    chk(r, e);
  endtask
  task automatic en_reg(input logic [5:0] a);
    @(posedge ref_clk);
    en_idx <= a;
    en_p <= 1'b1;
    @(posedge ref_clk);
    en_p <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_ident;
    rd(`UTR_OFS_PRODUCT, {1'b0, `UTR_PRODUCT_CODE});
    rd(`UTR_OFS_REVISION, {1'b0, `UTR_REVISION_CODE});
    rd(`UTR_OFS_INV_REV, {1'b0, ~`UTR_REVISION_CODE});
  endtask
  task automatic t_motion;
    @(posedge ref_clk);
    valid <= 1'b1;
    btn <= 5'h15;
    rd(`UTR_OFS_MOTION, 9'h095);
    @(posedge ref_clk);
    valid <= 1'b0;
    btn <= 5'h0A;
    rd(`UTR_OFS_MOTION, 9'h00A);
  endtask
  task automatic t_xy;
    @(posedge ref_clk);
    rx <= 8'h9C;
    stats.ydisp <= 8'h3B;
    rd(`UTR_OFS_YDISP, 9'h000);
    rd(`UTR_OFS_XDISP, 9'h09C);
    rd(`UTR_OFS_YDISP, 9'h03B);
    rd(`UTR_OFS_YDISP, 9'h000);
  endtask
  // exposure, pixel and wheel statistics each reach their own offset
  task automatic t_stats;
    @(posedge ref_clk);
    stats.exposure <= 16'h1C64;
    stats.pix_max <= 8'hE1;
    stats.pix_avg <= 8'h72;
    stats.pix_min <= 8'h0D;
    stats.pix_dump <= 8'h4F;
    stats.wheel <= 8'hFE;
    rd(`UTR_OFS_EXP_HI, 9'h01C);
    rd(`UTR_OFS_EXP_LO, 9'h064);
    rd(`UTR_OFS_PIX_MAX, 9'h0E1);
    rd(`UTR_OFS_PIX_AVG, 9'h072);
    rd(`UTR_OFS_PIX_MIN, 9'h00D);
    rd(`UTR_OFS_PIX_DUMP, 9'h04F);
    rd(`UTR_OFS_WHEEL, 9'h0FE);
  endtask
  task automatic t_setup;
    wr(`UTR_OFS_SETUP, 8'hA5, 9'h000);
    chk({1'b0, setup_bits}, 9'h0A5);
    rd(`UTR_OFS_SETUP, 9'h0A5);
    wr(`UTR_OFS_PRODUCT, 8'h00, 9'h000);
    rd(`UTR_OFS_PRODUCT, {1'b0, `UTR_PRODUCT_CODE});
  endtask
  task automatic t_gate;
    @(posedge ref_clk);
    gmap[`UTR_OFS_SURFACE_QUALITY] <= 1'b1;
    stats.surface_quality <= 8'h5E;
    rd(`UTR_OFS_SURFACE_QUALITY, 9'h100);
    wr(`UTR_OFS_SURFACE_QUALITY, 8'h00, 9'h100);
    rd(6'h20, 9'h100);
    en_reg(`UTR_OFS_SURFACE_QUALITY);
    rd(`UTR_OFS_SURFACE_QUALITY, 9'h05E);
    @(posedge ref_clk);
    usb_bus_reset <= 1'b1;
    @(posedge ref_clk);
    usb_bus_reset <= 1'b0;
    rd(`UTR_OFS_SURFACE_QUALITY, 9'h100);
    en_reg(`UTR_OFS_SURFACE_QUALITY);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({1'b0, setup_bits}, {1'b0, `UTR_SETUP_RST});
    rst_n <= 1'b1;
    rd(`UTR_OFS_SURFACE_QUALITY, 9'h100);
  endtask
  ////////////////////////////////////////////////////////////
  // the single place where the run ends
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // main sequence after ten reset cycles
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_ident();
    t_motion();
    t_xy();
    t_stats();
    t_setup();
    t_gate();
    give_verdict();
  end
  // watchdog: tests need well under 1000 cycles
  initial
  begin
    #50000;
    miscompares++;
    give_verdict();
  end
endmodule
